// >>> rtl/aclkb_pkg.sv
// How it works
// - The Op_code_a field is 0 for ARP request, 1 for reply, 2 for RARP request, 3 for RARP reply.
// - The IP-options flag is set when the IPv4 header length exceeds 5; options are not parsed.
// - The lifetime flag is set when the IPv4 TTL or IPv6 hop limit is above zero.
// - The traffic class byte (DSCP and ECN) goes into the type-of-service field.
// - The IPv4 destination field holds the IPv4 destination, or IPv6 source bits 63:32.
// - The IPv4 source field holds the IPv4 source, or IPv6 source bits 31:0.
// - The IPv6 destination field holds the IPv6 destination, or the IPv4 one in bits 31:0.
// - In the seven-tuple key for IPv4, source bits 127:125 carry fragmented, later and options.
// - The address-equal flag is set when destination and source IP addresses match.
// - The protocol field is the IPv4 protocol for IPv4 frames, else the IPv6 next header.
// - The TCP-or-UDP flag is set for IP frames whose protocol is 6 or 17.
// - The TCP flag is set only for IP frames whose protocol is 6.
// - Ports go into their fields; in the seven-tuple key IP frames without TCP_OR_UDP_FLAG carry the protocol as destination port.
// - A frame is IPv4 only when its EtherType is 0x800 and its version is 4.
// - Fragmented means more-fragments or nonzero offset; later fragment means nonzero offset.
package aclkb_pkg;
   localparam int ADDR_W = 128;
   localparam int NUM_FIELDS = 18;
   localparam int KEY_W_MAX = 301;
   localparam int NUM_KT = 6;

   typedef enum logic [2:0] {
      KT_IP4_VID = 3'h0,
      KT_ARP = 3'h1,
      KT_IP4_TCP_OR_UDP_FLAG = 3'h2,
      KT_IP4_OTHER = 3'h3,
      KT_IP6_VID = 3'h4,
      KT_SEVEN_TUPLE = 3'h5
   } aclkb_key_t;

   // Field order in the key, lowest bits first
   localparam int F_IPV4 = 0;
   localparam int F_FRAG = 1;
   localparam int F_LATER = 2;
   localparam int F_ARP_UNK = 3;
   localparam int F_ARP_OP = 4;
   localparam int F_OPTS = 5;
   localparam int F_LIFE = 6;
   localparam int F_TOS = 7;
   localparam int F_V4_DIP = 8;
   localparam int F_V4_SIP = 9;
   localparam int F_V6_DIP = 10;
   localparam int F_V6_SIP = 11;
   localparam int F_EQ = 12;
   localparam int F_PROTO = 13;
   localparam int F_TCPUDP = 14;
   localparam int F_TCP = 15;
   localparam int F_DPORT = 16;
   localparam int F_SPORT = 17;

   localparam int FIELD_W [NUM_FIELDS] = '{1, 1, 1, 1, 2, 1, 1, 8, 32, 32, 128, 128,
                                           1, 8, 1, 1, 16, 16};
   // Bit n set: field is part of key type n
   localparam logic [5:0] FIELD_IN [NUM_FIELDS] = '{6'h2c, 6'h0c, 6'h0c, 6'h02, 6'h02,
      6'h0c, 6'h2c, 6'h2c, 6'h0f, 6'h0f, 6'h30, 6'h30, 6'h2e, 6'h08, 6'h20, 6'h24,
      6'h24, 6'h24};

   // Fixed key positions used by checks
   localparam int K_ARP_OP_LSB = 1;
   localparam int K_TU_TOS_LSB = 5;
   localparam int K_OTH_DIP_LSB = 13;
   localparam int K_OTH_SIP_LSB = 45;
   localparam int K_7T_DIP_LSB = 10;
   localparam int K_7T_SIP_LSB = 138;
   localparam int K_7T_DPORT_LSB = 269;
   localparam int FLAG_B2 = 125;

   localparam logic [15:0] ETYPE_IPV4 = 16'h0800;
   localparam logic [15:0] ETYPE_IPV6 = 16'h86dd;
   localparam logic [3:0] IP_VER4 = 4'h4;
   localparam logic [3:0] IP_VER6 = 4'h6;
   localparam logic [3:0] IHL_MIN = 4'h5;
   localparam logic [7:0] PROTO_TCP = 8'h06;
   localparam logic [7:0] PROTO_UDP = 8'h11;
   localparam logic [15:0] ARP_RAW_REQ = 16'h0001;
   localparam logic [15:0] ARP_RAW_REPLY = 16'h0002;
   localparam logic [15:0] RARP_RAW_REQ = 16'h0003;
   localparam logic [15:0] RARP_RAW_REPLY = 16'h0004;
   localparam logic [1:0] ARP_OP_REQ = 2'h0;
   localparam logic [1:0] ARP_OP_REPLY = 2'h1;
   localparam logic [1:0] RARP_OP_REQ = 2'h2;
   localparam logic [1:0] RARP_OP_REPLY = 2'h3;

   localparam int WB_ADR_W = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_KEYCNT = 8'h08;
   localparam int CTRL_EN = 0;
   localparam int CTRL_KT_LSB = 1;
   localparam logic [3:0] CTRL_RESET = 4'hb;
   localparam int ST_IPV4 = 0;
   localparam int ST_OPT = 1;
   localparam int ST_LIFE = 2;
   localparam int ST_EQ = 3;
   localparam int ST_TCPUDP = 4;
   localparam int ST_TCP = 5;
   localparam int ST_FRAG = 6;
   localparam int ST_LATER = 7;
   localparam int ST_ARPUNK = 8;
   localparam int ST_W = 9;

   function automatic logic key_member(input int f, input logic [2:0] kt);
      key_member = (int'(kt) < NUM_KT) ? FIELD_IN[f][kt] : 1'b0;
   endfunction

   function automatic int key_len(input logic [2:0] kt);
      key_len = 0;
      for (int f = 0; f < NUM_FIELDS; f++) begin
         if (key_member(f, kt)) begin
            key_len = key_len + FIELD_W[f];
         end
      end
   endfunction
endpackage

// >>> rtl/aclkb_l3.sv
`timescale 1ns/1ps
module aclkb_l3 (
   input wire logic [15:0] i_etype,
   input wire logic [3:0] i_ip_ver,
   input wire logic [3:0] i_ip_hlen,
   input wire logic [7:0] i_hop_limit,
   input wire logic [7:0] i_tclass,
   input wire logic [31:0] i_ip4_sip,
   input wire logic [31:0] i_ip4_dip,
   input wire logic [127:0] i_ip6_sip,
   input wire logic [127:0] i_ip6_dip,
   input wire logic i_more_frag,
   input wire logic [12:0] i_frag_ofs,
   input wire logic i_seven_tuple,
   output logic o_ipv4_frame_flag,
   output logic o_ipv6_frame,
   output logic o_ip_has_options,
   output logic o_ip_lifetime_nonzero,
   output logic [7:0] o_ip_traffic_class,
   output logic [31:0] o_ipv4_dest_addr_field,
   output logic [31:0] o_ipv4_src_addr_field,
   output logic [127:0] o_ipv6_dest_addr_field,
   output logic [127:0] o_ipv6_src_addr_field,
   output logic o_ip_addr_equal_flag,
   output logic o_ip_fragmented_flag,
   output logic o_ip_later_fragment_flag
);
   logic v4;
   logic frag;
   logic later;
   logic opts;

   assign v4 = (i_etype == aclkb_pkg::ETYPE_IPV4) && (i_ip_ver == aclkb_pkg::IP_VER4);
   assign o_ipv4_frame_flag = v4;
   assign o_ipv6_frame = (i_etype == aclkb_pkg::ETYPE_IPV6) && (i_ip_ver == aclkb_pkg::IP_VER6);
   assign opts = v4 && (i_ip_hlen > aclkb_pkg::IHL_MIN);
   assign o_ip_has_options = opts;
   assign o_ip_lifetime_nonzero = (i_hop_limit != 8'h00);
   assign o_ip_traffic_class = i_tclass;
   assign frag = v4 && (i_more_frag || (i_frag_ofs != 13'h0000));
   assign later = v4 && (i_frag_ofs != 13'h0000);
   assign o_ip_fragmented_flag = frag;
   assign o_ip_later_fragment_flag = later;
   assign o_ipv4_dest_addr_field = v4 ? i_ip4_dip : i_ip6_sip[63:32];
   assign o_ipv4_src_addr_field = v4 ? i_ip4_sip : i_ip6_sip[31:0];
   assign o_ipv6_dest_addr_field = v4 ? {96'h0, i_ip4_dip} : i_ip6_dip;
   assign o_ip_addr_equal_flag = v4 ? (i_ip4_dip == i_ip4_sip) : (i_ip6_dip == i_ip6_sip);

   always_comb begin
      o_ipv6_src_addr_field = i_ip6_sip;
      if (v4) begin
         o_ipv6_src_addr_field = {96'h0, i_ip4_sip};
         if (i_seven_tuple) begin
            o_ipv6_src_addr_field[127:125] = {frag, later, opts};
         end
      end
   end
endmodule

// >>> rtl/aclkb_l4.sv
`timescale 1ns/1ps
module aclkb_l4 (
   input wire logic i_ipv4,
   input wire logic i_ipv6,
   input wire logic [7:0] i_ip4_proto,
   input wire logic [7:0] i_ip6_next_hdr,
   input wire logic [15:0] i_dport,
   input wire logic [15:0] i_sport,
   input wire logic [15:0] i_arp_op,
   input wire logic i_seven_tuple,
   output logic [7:0] o_ip_protocol_field,
   output logic o_tcp_or_udp_flag,
   output logic o_tcp_flag,
   output logic [15:0] o_l4_dest_port_field,
   output logic [15:0] o_l4_src_port_field,
   output logic [1:0] o_op_code_a,
   output logic o_arp_op_unrecognized
);
   logic [7:0] proto;
   logic is_ip;
   logic tu;

   assign proto = i_ipv4 ? i_ip4_proto : i_ip6_next_hdr;
   assign o_ip_protocol_field = proto;
   assign is_ip = i_ipv4 || i_ipv6;
   assign tu = is_ip && ((proto == aclkb_pkg::PROTO_TCP) || (proto == aclkb_pkg::PROTO_UDP));
   assign o_tcp_or_udp_flag = tu;
   assign o_tcp_flag = is_ip && (proto == aclkb_pkg::PROTO_TCP);
   assign o_l4_src_port_field = i_sport;
   assign o_l4_dest_port_field = (i_seven_tuple && is_ip && !tu) ? {8'h00, proto} : i_dport;

   always_comb begin
      o_op_code_a = aclkb_pkg::ARP_OP_REQ;
      o_arp_op_unrecognized = 1'b0;
      unique case (i_arp_op)
         aclkb_pkg::ARP_RAW_REQ: o_op_code_a = aclkb_pkg::ARP_OP_REQ;
         aclkb_pkg::ARP_RAW_REPLY: o_op_code_a = aclkb_pkg::ARP_OP_REPLY;
         aclkb_pkg::RARP_RAW_REQ: o_op_code_a = aclkb_pkg::RARP_OP_REQ;
         aclkb_pkg::RARP_RAW_REPLY: o_op_code_a = aclkb_pkg::RARP_OP_REPLY;
         default: o_arp_op_unrecognized = 1'b1;
      endcase
   end
endmodule

// >>> rtl/aclkb_top.sv
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module aclkb_top #(
   parameter int KEY_W = aclkb_pkg::KEY_W_MAX
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [aclkb_pkg::WB_ADR_W-1:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_frm_valid,
   input wire logic [15:0] i_etype,
   input wire logic [3:0] i_ip_ver,
   input wire logic [3:0] i_ip_hlen,
   input wire logic [7:0] i_hop_limit,
   input wire logic [7:0] i_tclass,
   input wire logic [31:0] i_ip4_sip,
   input wire logic [31:0] i_ip4_dip,
   input wire logic [127:0] i_ip6_sip,
   input wire logic [127:0] i_ip6_dip,
   input wire logic i_more_frag,
   input wire logic [12:0] i_frag_ofs,
   input wire logic [7:0] i_ip4_proto,
   input wire logic [7:0] i_ip6_next_hdr,
   input wire logic [15:0] i_dport,
   input wire logic [15:0] i_sport,
   input wire logic [15:0] i_arp_op,
   output logic o_key_valid,
   output logic [KEY_W-1:0] o_key,
   output logic [8:0] o_key_len,
   output logic [2:0] o_key_type
);
   for (genvar t = 0; t < aclkb_pkg::NUM_KT; t++) begin : g_len_chk
      if (aclkb_pkg::key_len(3'(t)) > KEY_W) begin : g_len_err
         $error("KEY_W too small for key type");
      end
   end

   logic [3:0] ctrl;
   logic [3:0] next_ctrl;
   logic ack;
   logic next_ack;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic key_valid;
   logic next_key_valid;
   logic [KEY_W-1:0] key;
   logic [KEY_W-1:0] next_key;
   logic [8:0] key_len;
   logic [8:0] next_key_len;
   logic [2:0] key_type;
   logic [2:0] next_key_type;
   logic [aclkb_pkg::ST_W-1:0] status;
   logic [aclkb_pkg::ST_W-1:0] next_status;
   logic [31:0] keycnt;
   logic [31:0] next_keycnt;

   logic [2:0] kt_sel;
   logic take;
   logic seven;
   logic ipv4_frame_flag;
   logic ipv6_frame;
   logic ip_has_options;
   logic ip_lifetime_nonzero;
   logic [7:0] ip_traffic_class;
   logic [31:0] ipv4_dest_addr_field;
   logic [31:0] ipv4_src_addr_field;
   logic [127:0] ipv6_dest_addr_field;
   logic [127:0] ipv6_src_addr_field;
   logic ip_addr_equal_flag;
   logic ip_fragmented_flag;
   logic ip_later_fragment_flag;
   logic [7:0] ip_protocol_field;
   logic tcp_or_udp_flag;
   logic tcp_flag;
   logic [15:0] l4_dest_port_field;
   logic [15:0] l4_src_port_field;
   logic [1:0] op_code_a;
   logic arp_op_unrecognized;
   logic [aclkb_pkg::ADDR_W-1:0] fval [aclkb_pkg::NUM_FIELDS];

   assign kt_sel = ctrl[aclkb_pkg::CTRL_KT_LSB +: 3];
   assign take = i_frm_valid && ctrl[aclkb_pkg::CTRL_EN];
   assign seven = (kt_sel == aclkb_pkg::KT_SEVEN_TUPLE);

   aclkb_l3 u_l3 (
      .i_etype(i_etype),
      .i_ip_ver(i_ip_ver),
      .i_ip_hlen(i_ip_hlen),
      .i_hop_limit(i_hop_limit),
      .i_tclass(i_tclass),
      .i_ip4_sip(i_ip4_sip),
      .i_ip4_dip(i_ip4_dip),
      .i_ip6_sip(i_ip6_sip),
      .i_ip6_dip(i_ip6_dip),
      .i_more_frag(i_more_frag),
      .i_frag_ofs(i_frag_ofs),
      .i_seven_tuple(seven),
      .o_ipv4_frame_flag(ipv4_frame_flag),
      .o_ipv6_frame(ipv6_frame),
      .o_ip_has_options(ip_has_options),
      .o_ip_lifetime_nonzero(ip_lifetime_nonzero),
      .o_ip_traffic_class(ip_traffic_class),
      .o_ipv4_dest_addr_field(ipv4_dest_addr_field),
      .o_ipv4_src_addr_field(ipv4_src_addr_field),
      .o_ipv6_dest_addr_field(ipv6_dest_addr_field),
      .o_ipv6_src_addr_field(ipv6_src_addr_field),
      .o_ip_addr_equal_flag(ip_addr_equal_flag),
      .o_ip_fragmented_flag(ip_fragmented_flag),
      .o_ip_later_fragment_flag(ip_later_fragment_flag)
   );

   aclkb_l4 u_l4 (
      .i_ipv4(ipv4_frame_flag),
      .i_ipv6(ipv6_frame),
      .i_ip4_proto(i_ip4_proto),
      .i_ip6_next_hdr(i_ip6_next_hdr),
      .i_dport(i_dport),
      .i_sport(i_sport),
      .i_arp_op(i_arp_op),
      .i_seven_tuple(seven),
      .o_ip_protocol_field(ip_protocol_field),
      .o_tcp_or_udp_flag(tcp_or_udp_flag),
      .o_tcp_flag(tcp_flag),
      .o_l4_dest_port_field(l4_dest_port_field),
      .o_l4_src_port_field(l4_src_port_field),
      .o_op_code_a(op_code_a),
      .o_arp_op_unrecognized(arp_op_unrecognized)
   );

   assign fval[aclkb_pkg::F_IPV4] = 128'(ipv4_frame_flag);
   assign fval[aclkb_pkg::F_FRAG] = 128'(ip_fragmented_flag);
   assign fval[aclkb_pkg::F_LATER] = 128'(ip_later_fragment_flag);
   assign fval[aclkb_pkg::F_ARP_UNK] = 128'(arp_op_unrecognized);
   assign fval[aclkb_pkg::F_ARP_OP] = 128'(op_code_a);
   assign fval[aclkb_pkg::F_OPTS] = 128'(ip_has_options);
   assign fval[aclkb_pkg::F_LIFE] = 128'(ip_lifetime_nonzero);
   assign fval[aclkb_pkg::F_TOS] = 128'(ip_traffic_class);
   assign fval[aclkb_pkg::F_V4_DIP] = 128'(ipv4_dest_addr_field);
   assign fval[aclkb_pkg::F_V4_SIP] = 128'(ipv4_src_addr_field);
   assign fval[aclkb_pkg::F_V6_DIP] = ipv6_dest_addr_field;
   assign fval[aclkb_pkg::F_V6_SIP] = ipv6_src_addr_field;
   assign fval[aclkb_pkg::F_EQ] = 128'(ip_addr_equal_flag);
   assign fval[aclkb_pkg::F_PROTO] = 128'(ip_protocol_field);
   assign fval[aclkb_pkg::F_TCPUDP] = 128'(tcp_or_udp_flag);
   assign fval[aclkb_pkg::F_TCP] = 128'(tcp_flag);
   assign fval[aclkb_pkg::F_DPORT] = 128'(l4_dest_port_field);
   assign fval[aclkb_pkg::F_SPORT] = 128'(l4_src_port_field);

   // Key build and capture
   always_comb begin
      int pos;
      pos = 0;
      next_key = key;
      next_key_len = key_len;
      next_key_type = key_type;
      next_key_valid = 1'b0;
      next_status = status;
      next_keycnt = keycnt;
      if (take) begin
         next_key = '0;
         for (int f = 0; f < aclkb_pkg::NUM_FIELDS; f++) begin
            if (aclkb_pkg::key_member(f, kt_sel)) begin
               for (int b = 0; b < aclkb_pkg::ADDR_W; b++) begin
                  if (b < aclkb_pkg::FIELD_W[f] && pos + b < KEY_W) begin
                     next_key[pos + b] = fval[f][b];
                  end
               end
               pos = pos + aclkb_pkg::FIELD_W[f];
            end
         end
         next_key_len = 9'(aclkb_pkg::key_len(kt_sel));
         next_key_type = kt_sel;
         next_key_valid = 1'b1;
         next_keycnt = keycnt + 32'h0000_0001;
         next_status[aclkb_pkg::ST_IPV4] = ipv4_frame_flag;
         next_status[aclkb_pkg::ST_OPT] = ip_has_options;
         next_status[aclkb_pkg::ST_LIFE] = ip_lifetime_nonzero;
         next_status[aclkb_pkg::ST_EQ] = ip_addr_equal_flag;
         next_status[aclkb_pkg::ST_TCPUDP] = tcp_or_udp_flag;
         next_status[aclkb_pkg::ST_TCP] = tcp_flag;
         next_status[aclkb_pkg::ST_FRAG] = ip_fragmented_flag;
         next_status[aclkb_pkg::ST_LATER] = ip_later_fragment_flag;
         next_status[aclkb_pkg::ST_ARPUNK] = arp_op_unrecognized;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         key <= '0;
         key_len <= 9'h000;
         key_type <= 3'h0;
         key_valid <= 1'b0;
         status <= '0;
         keycnt <= 32'h0000_0000;
      end else begin
         key <= next_key;
         key_len <= next_key_len;
         key_type <= next_key_type;
         key_valid <= next_key_valid;
         status <= next_status;
         keycnt <= next_keycnt;
      end
   end

   // Wishbone slave
   always_comb begin
      next_ack = i_wb_cyc && i_wb_stb && !ack;
      next_ctrl = ctrl;
      next_rdata = rdata;
      if (next_ack) begin
         next_rdata = 32'h0000_0000;
         if (i_wb_we) begin
            if (i_wb_adr == aclkb_pkg::REG_CTRL && i_wb_sel[0]) begin
               next_ctrl = i_wb_dat[3:0];
            end
         end else begin
            unique case (i_wb_adr)
               aclkb_pkg::REG_CTRL: next_rdata = {28'h000_0000, ctrl};
               aclkb_pkg::REG_STATUS: next_rdata = 32'(status);
               aclkb_pkg::REG_KEYCNT: next_rdata = keycnt;
               default: next_rdata = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ctrl <= aclkb_pkg::CTRL_RESET;
         ack <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         ctrl <= next_ctrl;
         ack <= next_ack;
         rdata <= next_rdata;
      end
   end

   assign o_wb_ack = ack;
   assign o_wb_dat = rdata;
   assign o_key_valid = key_valid;
   assign o_key = key;
   assign o_key_len = key_len;
   assign o_key_type = key_type;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   sequence take_s;
      i_frm_valid && ctrl[aclkb_pkg::CTRL_EN];
   endsequence
   sequence arp_reply_s;
      take_s ##0 (kt_sel == aclkb_pkg::KT_ARP && i_arp_op == aclkb_pkg::ARP_RAW_REPLY);
   endsequence
   sequence tuple_v4_s;
      take_s ##0 (seven && ipv4_frame_flag);
   endsequence

   op_code_a_a: assert property (arp_reply_s |=> o_key_valid &&
      o_key[aclkb_pkg::K_ARP_OP_LSB +: 2] == aclkb_pkg::ARP_OP_REPLY)
      else $error("ARP reply opcode wrong");
   options_flag_a: assert property (take_s |=> status[aclkb_pkg::ST_OPT] ==
      ($past(i_ip_hlen) > aclkb_pkg::IHL_MIN && $past(i_etype) == aclkb_pkg::ETYPE_IPV4 &&
      $past(i_ip_ver) == aclkb_pkg::IP_VER4))
      else $error("Options flag wrong");
   lifetime_flag_a: assert property (take_s |=>
      status[aclkb_pkg::ST_LIFE] == ($past(i_hop_limit) != 8'h00))
      else $error("Lifetime flag wrong");
   tos_field_a: assert property (take_s ##0 kt_sel == aclkb_pkg::KT_IP4_TCP_OR_UDP_FLAG |=>
      o_key[aclkb_pkg::K_TU_TOS_LSB +: 8] == $past(i_tclass))
      else $error("Traffic class field wrong");
   v4_addr_a: assert property (take_s ##0 (kt_sel == aclkb_pkg::KT_IP4_OTHER &&
      ipv4_frame_flag) |=> o_key[aclkb_pkg::K_OTH_SIP_LSB +: 32] == $past(i_ip4_sip) &&
      o_key[aclkb_pkg::K_OTH_DIP_LSB +: 32] == $past(i_ip4_dip))
      else $error("IPv4 address fields wrong");
   v6_dip_map_a: assert property (take_s ##0 (kt_sel == aclkb_pkg::KT_IP4_OTHER &&
      !ipv4_frame_flag) |=> o_key[aclkb_pkg::K_OTH_DIP_LSB +: 32] == $past(i_ip6_sip[63:32]))
      else $error("IPv6 source high word not mapped");
   tuple_dip_a: assert property (tuple_v4_s |=>
      o_key[aclkb_pkg::K_7T_DIP_LSB +: 32] == $past(i_ip4_dip))
      else $error("Tuple IPv4 destination wrong");
   tuple_frag_a: assert property (tuple_v4_s |=>
      o_key[aclkb_pkg::K_7T_SIP_LSB + aclkb_pkg::FLAG_B2 +: 3] == {$past(i_more_frag) ||
      $past(i_frag_ofs) != 13'h0000, $past(i_frag_ofs) != 13'h0000,
      $past(i_ip_hlen) > aclkb_pkg::IHL_MIN})
      else $error("Tuple fragment bits wrong");
   addr_equal_a: assert property (take_s ##0 ipv4_frame_flag |=>
      status[aclkb_pkg::ST_EQ] == ($past(i_ip4_dip) == $past(i_ip4_sip)))
      else $error("Address equal flag wrong");
   tcp_flag_a: assert property (take_s |=> status[aclkb_pkg::ST_TCP] ==
      (($past(ipv4_frame_flag) || $past(ipv6_frame)) && $past(ip_protocol_field) == 8'h06))
      else $error("TCP flag wrong");
   tuple_dport_a: assert property (take_s ##0 (seven && ipv4_frame_flag &&
      !tcp_or_udp_flag) |=> o_key[aclkb_pkg::K_7T_DPORT_LSB +: 16] == {8'h00, $past(i_ip4_proto)})
      else $error("Tuple port overload wrong");
   key_emit_a: assert property (take_s |=> o_key_valid &&
      o_key_len == 9'(aclkb_pkg::key_len($past(kt_sel))) ##1 !o_key_valid || $past(take))
      else $error("Key emission wrong");
endmodule

// >>> tb/aclkb_src.sv
`timescale 1ns/1ps
module aclkb_src (
   input wire logic i_clk,
   output logic o_frm_valid,
   output logic [437:0] o_frame
);
   initial begin
      o_frm_valid = 1'b0;
      o_frame = '0;
   end
   // Random frame: kind 0 IPv4, 1 IPv6, else ARP
   function automatic logic [437:0] gen(input int kind);
      logic [437:0] f;
      f = '0;
      for (int i = 0; i < 14; i++) begin
         f = {f[405:0], $urandom()};
      end
      f[437:418] = (kind == 0) ? 20'h0_8004 : (kind == 1) ? 20'h8_6dd6 : 20'h0_8064;
      f[417:414] = 4'h5 + 4'($urandom_range(1));
      if ($urandom_range(2) == 0) f[413:406] = 8'h00;
      if ($urandom_range(2) == 0) f[365:334] = f[397:366];
      if ($urandom_range(2) == 0) f[205:78] = f[333:206];
      if ($urandom_range(1) == 0) f[76:64] = 13'h0;
      if ($urandom_range(1) == 0) f[63:48] = $urandom_range(1) ? 16'h0606 : 16'h1111;
      f[15:0] = 16'($urandom_range(5));
      gen = f;
   endfunction
   task automatic drive(input logic [437:0] f);
      @(posedge i_clk);
      o_frm_valid <= 1'b1;
      o_frame <= f;
   endtask
   task automatic idle();
      @(posedge i_clk);
      o_frm_valid <= 1'b0;
      // Fields do not keep their value between frames
      o_frame <= ~o_frame;
   endtask
endmodule

// >>> tb/aclkb_top_tb.sv
`timescale 1ns/1ps
module aclkb_top_tb;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat, o_wb_dat;
   logic o_wb_ack, o_key_valid, frm_valid;
   logic [300:0] o_key;
   logic [8:0] o_key_len;
   logic [2:0] o_key_type;
   logic [2:0] kt = 3'h5;
   logic [437:0] fr;
   logic [312:0] exp_q[$];
   logic [312:0] e;
   int num_errors = 0;
   int num_checks = 0;
   int nkeys = 0;
   always #50 i_clk = ~i_clk;
   aclkb_src src_u (.i_clk(i_clk), .o_frm_valid(frm_valid), .o_frame(fr));
   aclkb_top dut_u (
      .i_clk(i_clk), .i_srst(i_srst), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat),
      .o_wb_ack(o_wb_ack), .i_frm_valid(frm_valid), .i_etype(fr[437:422]),
      .i_ip_ver(fr[421:418]), .i_ip_hlen(fr[417:414]), .i_hop_limit(fr[413:406]),
      .i_tclass(fr[405:398]), .i_ip4_sip(fr[397:366]), .i_ip4_dip(fr[365:334]),
      .i_ip6_sip(fr[333:206]), .i_ip6_dip(fr[205:78]), .i_more_frag(fr[77]),
      .i_frag_ofs(fr[76:64]), .i_ip4_proto(fr[63:56]), .i_ip6_next_hdr(fr[55:48]),
      .i_dport(fr[47:32]), .i_sport(fr[31:16]), .i_arp_op(fr[15:0]),
      .o_key_valid(o_key_valid), .o_key(o_key), .o_key_len(o_key_len),
      .o_key_type(o_key_type)
   );
   task automatic results();
      $display("Checks %0d, mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [312:0] seen, input logic [312:0] want);
      num_checks++;
      if (seen !== want) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge i_clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_wb_ack !== 1'b1 && n < 20);
      q = o_wb_dat;
      cyc <= 1'b0;
      if (o_wb_ack !== 1'b1) begin
         num_errors++;
         results();
      end
   endtask
   task automatic drain();
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 50) begin
         @(posedge i_clk);
         n++;
      end
      if (exp_q.size() != 0) begin
         num_errors++;
         results();
      end
   endtask
   // Expected {type, length, key} for one frame
   function automatic logic [312:0] expect_key(input logic [437:0] f, input logic [2:0] t);
      logic v4, ip, tu, tcp, frg, lat, opt, life, eq, unk;
      logic [7:0] pr;
      logic [31:0] d4, s4;
      logic [127:0] d6, s6;
      logic [1:0] op;
      logic [15:0] dp;
      v4 = f[437:422] == 16'h0800 && f[421:418] == 4'h4;
      ip = v4 || (f[437:422] == 16'h86dd && f[421:418] == 4'h6);
      pr = v4 ? f[63:56] : f[55:48];
      tu = ip && (pr == 8'h06 || pr == 8'h11);
      tcp = ip && pr == 8'h06;
      frg = v4 && (f[77] || f[76:64] != 13'h0);
      lat = v4 && f[76:64] != 13'h0;
      opt = v4 && f[417:414] > 4'h5;
      life = f[413:406] != 8'h00;
      d4 = v4 ? f[365:334] : f[269:238];
      s4 = v4 ? f[397:366] : f[237:206];
      d6 = v4 ? {96'h0, f[365:334]} : f[205:78];
      s6 = v4 ? {(t == 3'h5) ? {frg, lat, opt} : 3'h0, 93'h0, f[397:366]} : f[333:206];
      eq = v4 ? f[365:334] == f[397:366] : f[205:78] == f[333:206];
      unk = !(f[15:0] inside {[16'h1:16'h4]});
      op = unk ? 2'h0 : 2'(f[15:0] - 16'h1);
      dp = (ip && !tu) ? {8'h00, pr} : f[47:32];
      case (t)
         3'h0: expect_key = {t, 9'h040, 237'h0, s4, d4};
         3'h1: expect_key = {t, 9'h044, 233'h0, eq, s4, d4, op, unk};
         3'h2: expect_key = {t, 9'h06f, 190'h0, f[31:16], f[47:32], tcp, eq, s4, d4,
                             f[405:398], life, opt, lat, frg, v4};
         3'h4: expect_key = {t, 9'h100, 45'h0, s6, d6};
         3'h3: expect_key = {t, 9'h056, 215'h0, pr, eq, s4, d4, f[405:398], life, opt, lat,
                             frg, v4};
         3'h5: expect_key = {t, 9'h12d, f[31:16], dp, tcp, tu, eq, s6, d6, f[405:398], life, v4};
         default: expect_key = {t, 310'h0};
      endcase
   endfunction
   always @(posedge i_clk) begin
      if (o_key_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("unexpected key", 313'(1), 313'(0));
         end else begin
            e = exp_q.pop_front();
            check("key", {o_key_type, o_key_len, o_key}, e);
         end
      end
   end
   initial begin
      logic [437:0] f;
      logic [2:0] kts [7];
      kts = '{3'h1, 3'h3, 3'h5, 3'h6, 3'h0, 3'h2, 3'h4};
      void'($urandom(32'h0000_f126));
      repeat (20) @(posedge i_clk);
      i_srst <= 1'b0;
      check("key after reset", {o_key_type, o_key_len, o_key}, 313'(0));
      check("bus after reset", 313'({o_wb_ack, o_wb_dat}), 313'(0));
      wb(1'b0, 8'h00, 32'h0, rdat);
      check("ctrl reset", 313'(rdat), 313'(32'hb));
      wb(1'b0, 8'h0c, 32'h0, rdat);
      check("unmapped read", 313'(rdat), 313'(0));
      $display("Register test done");
      foreach (kts[i]) begin
         kt = kts[i];
         wb(1'b1, 8'h00, {28'h0, kt, 1'b1}, rdat);
         wb(1'b0, 8'h00, 32'h0, rdat);
         check("ctrl readback", 313'(rdat), 313'({kt, 1'b1}));
         repeat (25) begin
            f = src_u.gen((kt == 3'h1) ? 2 : int'($urandom_range(1)));
            exp_q.push_back(expect_key(f, kt));
            nkeys++;
            src_u.drive(f);
            if ($urandom_range(1) == 1) src_u.idle();
         end
         src_u.idle();
         drain();
         $display("Key type %0d done", kt);
      end
      wb(1'b0, 8'h08, 32'h0, rdat);
      check("key count", 313'(rdat), 313'(nkeys));
      wb(1'b1, 8'h00, 32'h0000_000a, rdat);
      src_u.drive(src_u.gen(0));
      src_u.idle();
      repeat (3) @(posedge i_clk);
      wb(1'b0, 8'h08, 32'h0, rdat);
      check("count while disabled", 313'(rdat), 313'(nkeys));
      $display("Disabled frame test done");
      results();
   end
endmodule
